/* File: verilog/tape_motion_pkg.sv */
// constants, register map and state type of the tape motion sequencer
package tape_motion_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned WR_DELAY_MS = 30;
  localparam int unsigned WR_DELAY_ALT_MS = 70;
  localparam int unsigned WR_DELAY_CYC = WR_DELAY_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned WR_DELAY_ALT_CYC = WR_DELAY_ALT_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned RD_CTL_DELAY_NS = 10000;
  localparam int unsigned RD_CTL_DELAY_CYC = (RD_CTL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = 23;
  // function word layout: four octal digits XXCD
  localparam int FN_W = 12;
  localparam int DIGIT_W = 3;
  localparam int FN_C_LSB = 3;
  localparam int FN_D_LSB = 0;
  localparam logic [2:0] FN_C_MOTION = 3'h1;
  localparam logic [2:0] CODE_REWIND = 3'h0;
  localparam logic [2:0] CODE_UNLOAD = 3'h1;
  localparam logic [2:0] CODE_BKSP = 3'h2;
  localparam logic [2:0] CODE_SFWD = 3'h3;
  localparam logic [2:0] CODE_SREV = 3'h4;
  localparam logic [2:0] CODE_WFM = 3'h5;
  localparam logic [2:0] CODE_SKIP = 3'h6;
  // frame data
  localparam int FRAME_W = 6;
  localparam logic [5:0] FILE_MARK_FRAME = 6'h0f;
  localparam logic [1:0] EOR_BLANK_LAST = 2'h2;
  // write timing chain times
  localparam logic [2:0] T0 = 3'h0;
  localparam logic [2:0] T1 = 3'h1;
  localparam logic [2:0] T2 = 3'h2;
  localparam logic [2:0] T3 = 3'h3;
  localparam logic [2:0] T5 = 3'h5;
  localparam logic [2:0] T7 = 3'h7;
  // register map
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_FUNC = 4'h0;
  localparam logic [3:0] OFF_CTRL = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [31:0] CTRL_RST = 32'h0;
  localparam logic [31:0] CTRL_MASK = 32'h7ff;
  localparam int CB_CONNECTED = 0;
  localparam int CB_READ_REQ = 1;
  localparam int CB_DATA_REQ = 2;
  localparam int CB_BUSY_LINE = 3;
  localparam int CB_INT_PEND = 4;
  localparam int CB_NONSTOP = 5;
  localparam int CB_REV_READ = 6;
  localparam int CB_ALT_DELAY = 7;
  localparam int CB_UNIT_LSB = 8;
  localparam int UNIT_W = 3;
  localparam int SB_BUSY = 0;
  localparam int SB_REJECT = 1;
  localparam int SB_LOST = 2;
  localparam int SB_LOCKOUT = 3;
  localparam int SB_RDCTL = 4;
  localparam int SB_WCTL = 5;
  localparam int SB_STATE_LSB = 8;
  localparam int SB_W2_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE, ST_WDELAY, ST_FMPASS, ST_MISS, ST_CHK, ST_TERM, ST_RDELAY, ST_READ, ST_SEEK
  } state_t;
endpackage : tape_motion_pkg

/* File: verilog/tape_motion_directive_sequencer.sv */
// tape motion directive decoder and sequencer with axi4-lite registers
// Operation
// RULE1 - function word XXCD, C digit one means motion
// RULE2 - only connected controller accepts a function
// RULE3 - codes 0010 rewind, 0011 unload, 0012 backspace
// RULE4 - 0013 search forward, 0014 search backward
// RULE5 - 0015 write file mark, 0016 skip bad spot
// RULE6 - backspace after reverse read moves forward
// RULE7 - skip bad spot: write motion, delay, terminate
// RULE8 - file mark is one frame 17 plus check
// RULE9 - after delay, transfer state set, pattern loaded
// RULE10 - three blank frames then check character
// RULE11 - file mark frame pass timing, times 0-7
// RULE12 - check character pass, then terminate and clear
// RULE13 - search forward sends forward, read, stop-on-mark
// RULE14 - handler returns end of record only at mark
// RULE15 - search backward same but reverse motion
// RULE16 - backspace sends reverse and read until record end
// RULE17 - rewind sends signal, controller becomes free
// RULE18 - unload sends signal, controller becomes free
// RULE19 - computer rejects search not taken in 100 us; no timeout here, ST_SEEK waits for end of record
// RULE20 - read requested while busy reports reject
// RULE21 - read starts only when all prerequisites hold
// RULE22 - read motion sets read, forward, conditioning
// RULE23 - read control sets 10 us after start
module tape_motion_directive_sequencer #(
  parameter int unsigned WR_DELAY_CYCLES = tape_motion_pkg::WR_DELAY_CYC,
  parameter int unsigned WR_DELAY_ALT_CYCLES = tape_motion_pkg::WR_DELAY_ALT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [tape_motion_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [tape_motion_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_handler_ready_reply,
  input wire logic i_handler_not_busy_reply,
  input wire logic i_end_of_record_reply,
  input wire logic i_read_sprocket,
  input wire logic i_lost_data_event,
  output logic o_forward,
  output logic o_reverse,
  output logic o_read,
  output logic o_write,
  output logic o_rewind,
  output logic o_unload,
  output logic o_stop_on_file_mark,
  output logic o_write_gate,
  output logic o_write_sprocket,
  output logic [tape_motion_pkg::FRAME_W-1:0] o_write_frame,
  output logic o_end_of_record_clear,
  output logic [tape_motion_pkg::UNIT_W-1:0] o_unit_select
);
  import tape_motion_pkg::*;

  state_t st_q;
  logic [2:0] tm_q;
  logic [1:0] miss_q;
  logic [DLY_W-1:0] dly_q;
  logic [31:0] ctrl_q;
  logic [FN_W-1:0] func_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q, wmask;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic write_motion_ff, write_control_ff, chan_to_out_xfer_ff, write_resync_ff;
  logic write_gate_ff, write_sprocket_ff, file_mark_request_ff, init_check_char_ff;
  logic write_term_one_ff, write_term_two_ff, end_of_record_clear;
  logic [FRAME_W-1:0] w1_q, w2_q;
  logic [1:0] frame_counter;
  logic read_motion_ff, read_data_lockout_ff, lost_data_ff, read_fwd_condition_ff;
  logic read_control_ff, read_ff, fwd_q, rev_q, stop_fm_q, rewind_q, unload_q;
  logic last_rev_q, skip_q, reject_q;

  // channel lines held in the control register
  logic connected_term, read_request_line, data_request_line, channel_busy_line;
  logic interrupt_pending_term, nonstop, rev_read, alt_delay;
  assign connected_term = ctrl_q[CB_CONNECTED];
  assign read_request_line = ctrl_q[CB_READ_REQ];
  assign data_request_line = ctrl_q[CB_DATA_REQ];
  assign channel_busy_line = ctrl_q[CB_BUSY_LINE];
  assign interrupt_pending_term = ctrl_q[CB_INT_PEND];
  assign nonstop = ctrl_q[CB_NONSTOP];
  assign rev_read = ctrl_q[CB_REV_READ];
  assign alt_delay = ctrl_q[CB_ALT_DELAY];

  // byte lane mask
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{w_strb_q[b]}};
    end
  endgenerate

  // bus write strobes and function decode
  logic wr_fire, wr_func, wr_ctrl, wr_stat, busy, fn_go, rd_go, wdly_done, rdly_done;
  logic [FN_W-1:0] wfunc;
  logic [2:0] fn_c, fn_d;
  logic [DLY_W-1:0] wr_dly_load;
  assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_func = wr_fire & (aw_addr_q == OFF_FUNC);
  assign wr_ctrl = wr_fire & (aw_addr_q == OFF_CTRL);
  assign wr_stat = wr_fire & (aw_addr_q == OFF_STATUS);
  assign wfunc = w_data_q[FN_W-1:0];
  assign fn_c = wfunc[FN_C_LSB +: DIGIT_W]; // RULE1
  assign fn_d = wfunc[FN_D_LSB +: DIGIT_W];
  assign busy = (st_q != ST_IDLE);
  assign fn_go = wr_func & connected_term & ~busy & (fn_c == FN_C_MOTION); // RULE2
  assign wdly_done = (st_q == ST_WDELAY) & (dly_q == '0);
  assign rdly_done = (st_q == ST_RDELAY) & (dly_q == '0);
  assign wr_dly_load = alt_delay ? DLY_W'(WR_DELAY_ALT_CYCLES - 1) : DLY_W'(WR_DELAY_CYCLES - 1);
  // read prerequisites
  assign rd_go = ~busy & ~fn_go & read_request_line & connected_term & ~interrupt_pending_term
    & ~lost_data_ff & i_handler_ready_reply & read_data_lockout_ff
    & (i_handler_not_busy_reply | nonstop); // RULE21

  // axi handshakes
  assign o_awready = ~aw_hold_q & ~bvalid_q;
  assign o_wready = ~w_hold_q & ~bvalid_q;
  assign o_arready = ~rvalid_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rresp = rresp_q;
  assign o_rdata = rdata_q;

  // write address and data capture, response
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_func | wr_ctrl | wr_stat) ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      unique case (i_araddr)
        OFF_FUNC: rdata_q <= 32'(func_q);
        OFF_CTRL: rdata_q <= ctrl_q;
        OFF_STATUS: begin
          rdata_q[SB_BUSY] <= busy;
          rdata_q[SB_REJECT] <= reject_q;
          rdata_q[SB_LOST] <= lost_data_ff;
          rdata_q[SB_LOCKOUT] <= read_data_lockout_ff;
          rdata_q[SB_RDCTL] <= read_control_ff;
          rdata_q[SB_WCTL] <= write_control_ff;
          rdata_q[SB_STATE_LSB +: 4] <= st_q;
          rdata_q[SB_W2_LSB +: FRAME_W] <= w2_q;
        end
        default: rresp_q <= RESP_DECERR;
      endcase
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // software registers and sticky flags, set wins over clear
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      ctrl_q <= CTRL_RST;
      func_q <= '0;
      reject_q <= 1'b0;
      lost_data_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ((ctrl_q & ~wmask) | (w_data_q & wmask)) & CTRL_MASK;
      end
      if (wr_func && connected_term) begin
        func_q <= wfunc;
      end
      if (wr_ctrl && busy && w_strb_q[0] && w_data_q[CB_READ_REQ] && !read_request_line) begin
        reject_q <= 1'b1; // RULE20
      end else if (wr_stat && w_strb_q[0] && w_data_q[SB_REJECT]) begin
        reject_q <= 1'b0;
      end
      if (i_lost_data_event) begin
        lost_data_ff <= 1'b1;
      end else if (wr_stat && w_strb_q[0] && w_data_q[SB_LOST]) begin
        lost_data_ff <= 1'b0;
      end
    end
  end

  // sequencer state, timing chain and delay counter
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      st_q <= ST_IDLE;
      tm_q <= T0;
      miss_q <= '0;
      dly_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          tm_q <= T0;
          if (fn_go) begin
            unique case (fn_d)
              CODE_BKSP, CODE_SFWD, CODE_SREV: st_q <= ST_SEEK;
              CODE_WFM, CODE_SKIP: begin
                st_q <= ST_WDELAY; // RULE7
                dly_q <= wr_dly_load;
              end
              default: st_q <= ST_IDLE; // RULE17 RULE18
            endcase
          end else if (rd_go) begin
            st_q <= ST_RDELAY;
            dly_q <= DLY_W'(RD_CTL_DELAY_CYC - 1);
          end
        end
        ST_WDELAY: begin
          dly_q <= dly_q - 1'b1;
          if (wdly_done) begin
            st_q <= skip_q ? ST_TERM : ST_FMPASS;
          end
        end
        ST_FMPASS: begin
          tm_q <= tm_q + 1'b1;
          miss_q <= '0;
          if (tm_q == T7) begin
            st_q <= ST_MISS;
          end
        end
        ST_MISS: begin
          tm_q <= tm_q + 1'b1;
          if (tm_q == T7) begin
            miss_q <= miss_q + 1'b1;
            if (miss_q == EOR_BLANK_LAST) begin
              st_q <= ST_CHK; // RULE10
            end
          end
        end
        ST_CHK: begin
          tm_q <= tm_q + 1'b1;
          if (tm_q == T7) begin
            st_q <= ST_TERM;
          end
        end
        ST_TERM: begin
          tm_q <= tm_q + 1'b1;
          if (tm_q == T2) begin
            st_q <= ST_IDLE;
          end
        end
        ST_RDELAY: begin
          dly_q <= dly_q - 1'b1;
          if (rdly_done) begin
            st_q <= ST_READ; // RULE23
          end
        end
        ST_READ: begin
          if (!read_request_line || i_end_of_record_reply) begin
            st_q <= ST_IDLE;
          end
        end
        ST_SEEK: begin
          if (i_end_of_record_reply) begin
            st_q <= ST_IDLE; // RULE16
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // write chain flip-flops for file mark and skip bad spot
  logic fm_t, ck_t, tm_t;
  assign fm_t = (st_q == ST_FMPASS);
  assign ck_t = (st_q == ST_CHK);
  assign tm_t = (st_q == ST_TERM);
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      write_motion_ff <= 1'b0;
      write_control_ff <= 1'b0;
      chan_to_out_xfer_ff <= 1'b0;
      write_resync_ff <= 1'b0;
      write_gate_ff <= 1'b0;
      write_sprocket_ff <= 1'b0;
      file_mark_request_ff <= 1'b0;
      init_check_char_ff <= 1'b0;
      write_term_one_ff <= 1'b0;
      write_term_two_ff <= 1'b0;
      end_of_record_clear <= 1'b1;
      w1_q <= '0;
      w2_q <= '0;
      frame_counter <= '0;
    end else begin
      if (fn_go && (fn_d == CODE_WFM || fn_d == CODE_SKIP)) begin
        write_motion_ff <= 1'b1; // RULE7
        file_mark_request_ff <= (fn_d == CODE_WFM); // RULE8
        frame_counter <= '0;
      end
      if (wdly_done) begin
        write_control_ff <= 1'b1;
        end_of_record_clear <= 1'b0;
        chan_to_out_xfer_ff <= ~skip_q; // RULE9
        write_resync_ff <= ~skip_q;
        write_term_one_ff <= skip_q; // RULE7
      end
      if (fm_t && tm_q == T0) write_gate_ff <= 1'b1; // RULE11
      if (fm_t && tm_q == T1) w2_q <= w1_q; // RULE11
      if (fm_t && tm_q == T2) w1_q <= FILE_MARK_FRAME; // RULE8 RULE9
      if ((fm_t || ck_t) && tm_q == T3) write_sprocket_ff <= 1'b1; // RULE11 RULE12
      if (fm_t && tm_q == T3) file_mark_request_ff <= 1'b0;
      if (fm_t && tm_q == T5) begin
        frame_counter <= frame_counter + 1'b1; // RULE11
        init_check_char_ff <= 1'b1;
      end
      if (fm_t && tm_q == T7) begin
        write_sprocket_ff <= 1'b0; // RULE11
        write_resync_ff <= 1'b0;
        write_gate_ff <= 1'b0;
        chan_to_out_xfer_ff <= 1'b0;
      end
      if (ck_t && tm_q == T1) begin
        w2_q <= w1_q;
        w1_q <= '0; // RULE12
        write_term_one_ff <= 1'b1;
      end
      if (ck_t && tm_q == T7) begin
        write_sprocket_ff <= 1'b0;
        init_check_char_ff <= 1'b0;
      end
      if (tm_t && tm_q == T0) begin
        write_term_two_ff <= 1'b1; // RULE12
        write_term_one_ff <= 1'b0;
        write_motion_ff <= 1'b0;
      end
      if (tm_t && tm_q == T1) begin
        write_control_ff <= 1'b0; // RULE12
        end_of_record_clear <= 1'b1;
      end
      if (tm_t && tm_q == T2) write_term_two_ff <= 1'b0;
    end
  end

  // handler motion and read flip-flops
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      fwd_q <= 1'b0;
      rev_q <= 1'b0;
      read_ff <= 1'b0;
      stop_fm_q <= 1'b0;
      rewind_q <= 1'b0;
      unload_q <= 1'b0;
      read_motion_ff <= 1'b0;
      read_fwd_condition_ff <= 1'b0;
      read_control_ff <= 1'b0;
      read_data_lockout_ff <= 1'b1;
      last_rev_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      rewind_q <= fn_go && (fn_d == CODE_REWIND); // RULE3 RULE17
      unload_q <= fn_go && (fn_d == CODE_UNLOAD); // RULE3 RULE18
      if (fn_go) begin
        last_rev_q <= 1'b0;
        skip_q <= (fn_d == CODE_SKIP); // RULE5
        unique case (fn_d)
          CODE_BKSP: begin
            read_ff <= 1'b1; // RULE16
            fwd_q <= last_rev_q; // RULE6
            rev_q <= ~last_rev_q;
          end
          CODE_SFWD, CODE_SREV: begin
            read_ff <= 1'b1; // RULE4 RULE13
            fwd_q <= (fn_d == CODE_SFWD);
            rev_q <= (fn_d == CODE_SREV); // RULE15
            stop_fm_q <= 1'b1;
          end
          CODE_WFM, CODE_SKIP: fwd_q <= 1'b1;
          default: fwd_q <= fwd_q;
        endcase
      end else if (rd_go) begin
        read_motion_ff <= 1'b1; // RULE22
        read_ff <= 1'b1;
        fwd_q <= ~rev_read;
        rev_q <= rev_read;
        read_fwd_condition_ff <= ~rev_read;
        last_rev_q <= rev_read;
      end
      if (rdly_done) read_control_ff <= 1'b1; // RULE23
      if (st_q == ST_READ && i_read_sprocket && read_data_lockout_ff) begin
        read_data_lockout_ff <= 1'b0; // first frame: motion now self-sustaining
        read_ff <= 1'b0;
        fwd_q <= 1'b0;
        rev_q <= 1'b0;
      end
      if (tm_t && tm_q == T0) fwd_q <= 1'b0;
      if ((st_q == ST_READ && (!read_request_line || i_end_of_record_reply))
          || (st_q == ST_SEEK && i_end_of_record_reply)) begin
        read_motion_ff <= 1'b0;
        read_control_ff <= 1'b0;
        read_fwd_condition_ff <= 1'b0;
        read_data_lockout_ff <= 1'b1;
        read_ff <= 1'b0;
        fwd_q <= 1'b0;
        rev_q <= 1'b0;
        stop_fm_q <= 1'b0; // RULE14
      end
    end
  end

  // handler outputs
  assign o_forward = fwd_q;
  assign o_reverse = rev_q;
  assign o_read = read_ff;
  assign o_write = write_control_ff;
  assign o_rewind = rewind_q;
  assign o_unload = unload_q;
  assign o_stop_on_file_mark = stop_fm_q;
  assign o_write_gate = write_gate_ff;
  assign o_write_sprocket = write_sprocket_ff;
  assign o_write_frame = w1_q;
  assign o_end_of_record_clear = end_of_record_clear;
  assign o_unit_select = ctrl_q[CB_UNIT_LSB +: UNIT_W];

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_func(logic [2:0] d);
    wr_func && connected_term && !busy && fn_c == FN_C_MOTION && fn_d == d;
  endsequence
  sequence s_fm_frame;
    (st_q == ST_FMPASS && tm_q == T2) ##1 (w1_q == FILE_MARK_FRAME && !write_sprocket_ff)
      ##1 (write_sprocket_ff && !file_mark_request_ff);
  endsequence

  property p_ignore_unconnected;
    (wr_func && !connected_term && !busy) |=> (st_q == ST_IDLE && !o_rewind && !o_unload);
  endproperty
  a_ignore_unconnected: assert property (p_ignore_unconnected) else $error("function taken while unconnected"); // RULE2
  property p_rewind;
    s_func(CODE_REWIND) |=> (o_rewind && st_q == ST_IDLE) ##1 !o_rewind;
  endproperty
  a_rewind: assert property (p_rewind) else $error("rewind pulse or release wrong"); // RULE17
  property p_search_fwd;
    s_func(CODE_SFWD) |=> (o_forward && !o_reverse && o_read && o_stop_on_file_mark);
  endproperty
  a_search_fwd: assert property (p_search_fwd) else $error("search forward signals wrong"); // RULE13
  property p_search_rev;
    s_func(CODE_SREV) |=> (o_reverse && !o_forward && o_read && o_stop_on_file_mark);
  endproperty
  a_search_rev: assert property (p_search_rev) else $error("search backward signals wrong"); // RULE15
  property p_bksp_dir;
    (s_func(CODE_BKSP) and (last_rev_q == 1'b1)) |=> (o_forward && !o_reverse && o_read);
  endproperty
  a_bksp_dir: assert property (p_bksp_dir) else $error("backspace after reverse read wrong"); // RULE6
  property p_fm_frame;
    (st_q == ST_FMPASS && tm_q == T2) |-> s_fm_frame;
  endproperty
  a_fm_frame: assert property (p_fm_frame) else $error("file mark frame pass wrong"); // RULE11
  property p_blank_frames;
    $rose(st_q == ST_MISS) |-> (st_q == ST_MISS && !o_write_sprocket) [*8] ##17 (st_q == ST_CHK);
  endproperty
  a_blank_frames: assert property (p_blank_frames) else $error("check not after three frames"); // RULE10
  property p_check_char;
    (st_q == ST_CHK && tm_q == T1) |=> (w1_q == '0 && write_term_one_ff)
      ##9 (!o_write && !o_forward && o_end_of_record_clear);
  endproperty
  a_check_char: assert property (p_check_char) else $error("check character or stop wrong"); // RULE12
  property p_skip;
    (wdly_done && skip_q) |=> (o_write && write_term_one_ff && st_q == ST_TERM && !o_write_gate);
  endproperty
  a_skip: assert property (p_skip) else $error("skip bad spot termination wrong"); // RULE7
  property p_read_start;
    rd_go |=> (read_motion_ff && o_read && (o_forward == read_fwd_condition_ff)) ##1 !read_control_ff;
  endproperty
  a_read_start: assert property (p_read_start) else $error("read start signals wrong"); // RULE22
  property p_read_ctl;
    $rose(st_q == ST_RDELAY) |-> !read_control_ff [*8] ##[1:1000] read_control_ff;
  endproperty
  a_read_ctl: assert property (p_read_ctl) else $error("read control not set in time"); // RULE23
  property p_read_gate;
    $rose(read_motion_ff) |-> $past(connected_term && !lost_data_ff && i_handler_ready_reply);
  endproperty
  a_read_gate: assert property (p_read_gate) else $error("read began without prerequisites"); // RULE21
  property p_reject;
    (wr_ctrl && busy && w_strb_q[0] && w_data_q[CB_READ_REQ] && !read_request_line) |=> reject_q;
  endproperty
  a_reject: assert property (p_reject) else $error("busy read not rejected"); // RULE20
endmodule : tape_motion_directive_sequencer

/* File: sim/tape_handler_model.sv */
// behavioural tape handler on the far side of the sequencer
module tape_handler_model (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_read,
  input wire logic i_stop_fm,
  input wire logic i_rewind,
  output logic o_ready,
  output logic o_not_busy,
  output logic o_eor
);
  timeunit 1ns;
  timeprecision 1ns;
  int mot_cnt;
  int rew_cnt;
  // tape runs over ordinary gaps while stop-on-mark is up
  always_ff @(posedge i_core_clk) begin
    mot_cnt <= (!i_rstn || !i_read) ? 0 : mot_cnt + 1;
    o_eor <= i_read && mot_cnt == (i_stop_fm ? 3000 : 1500);
    o_not_busy <= !i_read;
  end
  // rewind holds ready low until load point
  always_ff @(posedge i_core_clk) begin
    rew_cnt <= !i_rstn ? 0 : i_rewind ? 40 : (rew_cnt > 0) ? rew_cnt - 1 : 0;
    o_ready <= i_rstn && rew_cnt == 0;
  end
endmodule : tape_handler_model

/* File: sim/tape_motion_directive_sequencer_tb.sv */
// self-checking bench for the tape motion directive sequencer
module tape_motion_directive_sequencer_tb;
  import tape_motion_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [3:0] i_awaddr = 4'h0;
  logic [3:0] i_araddr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'hf;
  logic i_awvalid = 1'b0;
  logic i_wvalid = 1'b0;
  logic i_arvalid = 1'b0;
  logic i_bready = 1'b1;
  logic i_rready = 1'b1;
  logic i_read_sprocket = 1'b0;
  logic i_lost_data_event = 1'b0;
  logic i_handler_ready_reply, i_handler_not_busy_reply, i_end_of_record_reply;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_forward, o_reverse, o_read;
  logic o_write, o_rewind, o_unload, o_stop_on_file_mark, o_write_gate, o_write_sprocket;
  logic o_end_of_record_clear;
  logic [1:0] o_bresp, o_rresp, rr;
  logic [31:0] o_rdata, q;
  logic [5:0] o_write_frame;
  logic [2:0] o_unit_select;
  int err_count = 0;
  int comparisons = 0;
  int seed = 51;
  int last_rev = 0;
  int n;
  logic [7:0] seen = 8'h00;
  wire [7:0] mot = {o_forward, o_reverse, o_read, o_stop_on_file_mark, o_rewind, o_unload,
    o_write, o_write_gate};
  tape_motion_directive_sequencer #(.WR_DELAY_CYCLES(20), .WR_DELAY_ALT_CYCLES(30)) u_dut (
    .i_core_clk, .i_rstn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata,
    .o_rresp, .o_rvalid, .i_rready, .i_handler_ready_reply, .i_handler_not_busy_reply,
    .i_end_of_record_reply, .i_read_sprocket, .i_lost_data_event, .o_forward, .o_reverse,
    .o_read, .o_write, .o_rewind, .o_unload, .o_stop_on_file_mark, .o_write_gate,
    .o_write_sprocket, .o_write_frame, .o_end_of_record_clear, .o_unit_select);
  tape_handler_model u_handler (.i_core_clk, .i_rstn, .i_read(o_read),
    .i_stop_fm(o_stop_on_file_mark), .i_rewind(o_rewind | o_unload),
    .o_ready(i_handler_ready_reply), .o_not_busy(i_handler_not_busy_reply),
    .o_eor(i_end_of_record_reply));
  // verdict and end of run
  task automatic results();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic lim(input int m);
    if (n >= m) begin
      err_count++;
      results();
    end
  endtask : lim
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge i_core_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      seen = seen | mot;
      rr = o_bresp;
      if (o_bvalid) break;
    end
    lim(99);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge i_core_clk);
      if (o_arready) i_arvalid <= 1'b0;
      q = o_rdata;
      rr = o_rresp;
      if (o_rvalid) break;
    end
    lim(99);
  endtask : rd
  task automatic wt(input logic [7:0] m, input logic [7:0] v);
    for (n = 0; n < 9000 && (mot & m) !== v; n++) @(posedge i_core_clk);
    lim(9000);
  endtask : wt
  // model: expected handler lines for each motion code
  task automatic run(input int c);
    logic [7:0] e;
    e = c == 0 ? 8'h08 : c == 1 ? 8'h04 : c == 3 ? 8'hb0 : c == 4 ? 8'h70 : 8'h80;
    if (c == 2) e = last_rev ? 8'ha0 : 8'h60;
    last_rev = 0;
    seen = 8'h00;
    wr(OFF_FUNC, {20'h0, 6'($random(seed)), FN_C_MOTION, 3'(c)});
    chk(rr, RESP_OKAY);
    if (c > 1) wt(8'hfc, e);
    chk((c > 1 ? mot : seen) & 8'hfc, e);
    if (c == 5) begin
      wt(8'h01, 8'h01);
      repeat (4) @(posedge i_core_clk);
      chk({o_write_sprocket, o_write_frame}, {1'b1, FILE_MARK_FRAME});
    end
    wt(8'hff, 8'h00);
    chk(o_end_of_record_clear, 1'b1);
  endtask : run
  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end
  // main sequence
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    wr(OFF_FUNC, 32'hb);
    repeat (4) @(posedge i_core_clk);
    chk(mot, 8'h00);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_FUNC, 32'h23);
    repeat (4) @(posedge i_core_clk);
    chk(mot, 8'h00);
    wr(OFF_FUNC, 32'hb);
    wr(OFF_CTRL, 32'h43);
    rd(OFF_STATUS);
    chk(q[1], 1'b1);
    wr(OFF_STATUS, 32'h2);
    wt(8'hff, 8'h60);
    chk(mot, 8'h60);
    rd(OFF_STATUS);
    chk(q[4], 1'b0);
    repeat (1000) @(posedge i_core_clk);
    rd(OFF_STATUS);
    chk(q[4], 1'b1);
    wr(OFF_CTRL, 32'h501);
    wt(8'hff, 8'h00);
    chk(o_unit_select, 3'h5);
    last_rev = 1;
    run(2);
    for (int c = 0; c < 7; c++) run(c);
    rd(4'hc);
    chk(rr, RESP_DECERR);
    results();
  end
endmodule : tape_motion_directive_sequencer_tb
